// ==== verilog/mds_pkg.sv ====
// Shared constants and types for the memory download sequencer.
// Assumes a 10 MHz system clock; the link clock comes from the programmer.
`default_nettype none

package mds_pkg;

    // ------------------------------------------------------------
    // Serial instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ENABLE     = 8'hac;
    localparam logic [7:0] ENABLE_ECHO   = 8'h53;
    localparam logic [7:0] ERASE_ARG     = 8'h80;
    localparam logic [7:0] OP_LOAD_PAGE  = 8'h40;
    localparam logic [7:0] OP_WRITE_PAGE = 8'h4c;
    localparam logic [7:0] OP_READ_FLASH = 8'h20;
    localparam logic [7:0] OP_READ_EE    = 8'ha0;
    localparam logic [7:0] OP_WRITE_EE   = 8'hc0;
    localparam logic [7:0] ERASED_BYTE   = 8'hff;

    // ------------------------------------------------------------
    // Link framing: bit counter positions
    // ------------------------------------------------------------
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [5:0] HDR_LAST  = 6'h17;
    localparam logic [5:0] WORD_LAST = 6'h1f;

    // ------------------------------------------------------------
    // Parallel mode
    // ------------------------------------------------------------
    localparam logic [7:0] PAR_CMD_EE_WRITE = 8'h11;
    localparam logic [7:0] EE_HIGH_MAX      = 8'h03;
    localparam logic [1:0] PAR_XA_ADDR      = 2'h0;
    localparam logic [1:0] PAR_XA_DATA      = 2'h1;
    localparam logic [1:0] PAR_XA_CMD       = 2'h2;

    // ------------------------------------------------------------
    // Geometry and timing
    // ------------------------------------------------------------
    localparam int PAGE_OFS_BITS = 6;
    localparam int PAGE_NUM_BITS = 8;
    localparam int EE_ADDR_BITS  = 10;
    localparam int MCLK_KHZ      = 10000;
    localparam int FLASH_WD_US   = 4500;
    localparam int EE_WD_US      = 9000;
    localparam int FLASH_WD_CYC_DEF = FLASH_WD_US * MCLK_KHZ / 1000;
    localparam int EE_WD_CYC_DEF    = EE_WD_US * MCLK_KHZ / 1000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] arg_hi;
        logic [7:0] arg_lo;
        logic [7:0] data;
    } mds_instr_t;

    typedef struct packed {
        logic       full;
        mds_instr_t w;
    } mds_xfer_t;

    typedef enum logic [2:0] {
        ENG_IDLE,
        ENG_ERASE,
        ENG_PAGE,
        ENG_EE_CLR,
        ENG_EE_PROG
    } mds_eng_t;

    function automatic logic mds_is_read(input logic [7:0] op);
        return (op == OP_READ_FLASH) || (op == OP_READ_EE);
    endfunction

endpackage

`default_nettype wire

// ==== verilog/mds_sync2.sv ====
// Two-stage synchroniser for a bundle of pin levels.
// Assumes each bit is a level that stays put for several clocks.
`timescale 1ns/1ps
`default_nettype none

module mds_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Levels
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// ==== verilog/mds_word_cdc.sv ====
// Toggle handshake carrying one word between two clock domains.
// Assumes the source holds off a new load until the last one has landed.
`timescale 1ns/1ps
`default_nettype none

module mds_word_cdc #(
    parameter int WIDTH = 8
) (
    // Source domain
    input  wire logic             src_clk_i,
    input  wire logic             src_rst_i,
    input  wire logic             src_load_i,
    input  wire logic [WIDTH-1:0] src_data_i,
    // Destination domain
    input  wire logic             dst_clk_i,
    input  wire logic             dst_rst_i,
    output logic                  dst_valid_o,
    output logic      [WIDTH-1:0] dst_data_o
);

    logic [WIDTH-1:0] hold_reg;
    logic             tog_reg;
    logic             s1_reg;
    logic             s2_reg;
    logic             s3_reg;

    // Word stays frozen in the source until the next load
    always_ff @(posedge src_clk_i or posedge src_rst_i) begin
        if (src_rst_i) begin
            hold_reg <= '0;
            tog_reg  <= 1'b0;
        end else if (src_load_i) begin
            hold_reg <= src_data_i;
            tog_reg  <= ~tog_reg;
        end
    end

    wire logic arrive = s2_reg ^ s3_reg;

    always_ff @(posedge dst_clk_i or posedge dst_rst_i) begin
        if (dst_rst_i) begin
            s1_reg      <= 1'b0;
            s2_reg      <= 1'b0;
            s3_reg      <= 1'b0;
            dst_valid_o <= 1'b0;
            dst_data_o  <= '0;
        end else begin
            s1_reg      <= tog_reg;
            s2_reg      <= s1_reg;
            s3_reg      <= s2_reg;
            dst_valid_o <= arrive;
            if (arrive) begin
                dst_data_o <= hold_reg;
            end
        end
    end

endmodule

`default_nettype wire

// ==== verilog/mds_sequencer.sv ====
// Memory download sequencer: serial loading of flash and EEPROM, parallel loading of EEPROM.
// Assumes a programmer drives sck_i, mosi_i and prog_reset_i; mclk_i runs at 10 MHz.
//
// Summary of operation
// [R1] Echo second enable byte during third byte
// [R2] Programmer always sends all four bytes
// [R3] Programmer resyncs with SCK pulse, 32 tries
// [R4] Programmer waits after erase, pulses reset
// [R5] Flash erased only by chip erase
// [R6] Page buffer loaded bytewise, 6-bit offset
// [R7] Write-page commits buffer at 8-bit page
// [R8] Programmer waits flash delay between pages
// [R9] EEPROM byte write erases then programs
// [R10] Programmer waits EEPROM delay between bytes
// [R11] Read instruction returns selected byte
// [R12] Reset high ends programming mode
// [R13] Busy flash page reads as all ones
// [R14] Whole page written at one time
// [R15] Programmer cannot poll all-ones flash data
// [R16] Busy EEPROM byte reads as all ones
// [R17] Programmer handles all-ones EEPROM bytes
// [R18] Parallel write starts with command, high 0..3
// [R19] Write strobe with low select starts, busy
// [R20] Ready returns high when write completes
`timescale 1ns/1ps
`default_nettype none

module mds_sequencer
    import mds_pkg::*;
#(
    parameter int PAGE_W       = PAGE_OFS_BITS,
    parameter int PNUM_W       = PAGE_NUM_BITS,
    parameter int EE_W         = EE_ADDR_BITS,
    parameter int FLASH_WD_CYC = FLASH_WD_CYC_DEF,
    parameter int EE_WD_CYC    = EE_WD_CYC_DEF
) (
    // System clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // Serial link from the programmer
    input  wire logic       sck_i,
    input  wire logic       prog_reset_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // Parallel programming pins
    input  wire logic       par_mode_i,
    input  wire logic [1:0] par_xa_i,
    input  wire logic       par_load_i,
    input  wire logic       byte_select_first_i,
    input  wire logic       par_wr_n_i,
    input  wire logic [7:0] par_data_i,
    output logic            program_done_indicator_o,
    // Status
    output logic            prog_active_o
);

    localparam int FA_W        = PAGE_W + PNUM_W;
    localparam int FLASH_BYTES = 2 ** FA_W;
    localparam int PAGE_BYTES  = 2 ** PAGE_W;
    localparam int EE_BYTES    = 2 ** EE_W;

    generate
        if (FA_W > 16 || PNUM_W > 8 || PAGE_W > 8 || EE_W > FA_W || FLASH_WD_CYC < FLASH_BYTES
            || EE_WD_CYC < 2) begin : g_bad_params
            $error("mds_sequencer: unsupported parameter set");
        end
    endgenerate

    // ------------------------------------------------------------
    // Link domain: shift in, echo out
    // ------------------------------------------------------------
    // Reset pin high holds the framing at byte zero; a lone SCK pulse shifts alignment
    wire logic link_rst = rst_i | prog_reset_i;

    logic [5:0]  bit_cnt_reg;
    logic [31:0] sh_in_reg;
    logic [7:0]  sh_out_reg;
    logic [7:0]  rd_byte_link;

    wire logic [31:0] sh_in_next  = {sh_in_reg[30:0], mosi_i};
    wire logic        byte_end    = (bit_cnt_reg[2:0] == BYTE_LAST);
    wire logic        hdr_end     = (bit_cnt_reg == HDR_LAST);
    wire logic        word_end    = (bit_cnt_reg == WORD_LAST);
    wire logic        ret_read    = word_end && mds_is_read(sh_in_next[31:24]);
    wire logic [5:0]  bit_cnt_next = word_end ? 6'h00 : bit_cnt_reg + 6'h01;
    wire logic [7:0]  sh_out_next = !byte_end ? {sh_out_reg[6:0], 1'b0}
                                  : ret_read ? rd_byte_link
                                  : sh_in_next[7:0];

    always_ff @(posedge sck_i or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_reg <= 6'h00;
            sh_in_reg   <= 32'h0000_0000;
            sh_out_reg  <= 8'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_next; // R3
            sh_in_reg   <= sh_in_next;
            sh_out_reg  <= sh_out_next; // R1
        end
    end

    assign miso_o = sh_out_reg[7];

    // Header goes over early so the read byte has the word's last eight SCK edges to arrive; it can still miss the word end
    // Header bytes still sit low in the shifter, so move them up to the word's field places
    wire logic [31:0] hdr_word = word_end ? sh_in_next : {sh_in_next[23:0], 8'h00};
    mds_xfer_t xfer;
    logic      xfer_valid;

    mds_word_cdc #(
        .WIDTH      ($bits(mds_xfer_t))
    ) u_to_sys (
        .src_clk_i  (sck_i),
        .src_rst_i  (rst_i),
        .src_load_i (hdr_end | word_end),
        .src_data_i ({word_end, hdr_word}),
        .dst_clk_i  (mclk_i),
        .dst_rst_i  (rst_i),
        .dst_valid_o(xfer_valid),
        .dst_data_o (xfer)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [14:0] pin_s;

    mds_sync2 #(
        .WIDTH(15)
    ) u_pins (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .d_i  ({prog_reset_i, par_mode_i, par_load_i, par_wr_n_i, byte_select_first_i, par_xa_i, par_data_i}),
        .q_o  (pin_s)
    );

    wire logic       prog_pin_s = pin_s[14];
    wire logic       par_mode_s = pin_s[13];
    wire logic       par_ld_s   = pin_s[12];
    wire logic       par_wr_n_s = pin_s[11];
    wire logic       bs1_s      = pin_s[10];
    wire logic [1:0] xa_s       = pin_s[9:8];
    wire logic [7:0] pdata_s    = pin_s[7:0];

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    mds_eng_t         eng_reg;
    mds_eng_t         eng_next;
    logic [31:0]      timer_reg;
    logic [FA_W-1:0]  sweep_reg;
    logic [PNUM_W-1:0] busy_page_reg;
    logic [EE_W-1:0]  ee_addr_reg;
    logic [7:0]       ee_data_reg;
    logic             prog_active_reg;
    logic             rdy_reg;
    logic             ld_prev_reg;
    logic             wr_prev_reg;
    logic [7:0]       par_cmd_reg;
    logic [1:0]       par_hi_reg;
    logic [7:0]       par_lo_reg;
    logic [7:0]       par_dat_reg;

    logic [7:0] flash_mem [FLASH_BYTES];
    logic [7:0] ee_mem    [EE_BYTES];
    logic [7:0] page_buf  [PAGE_BYTES];

    wire logic [7:0]      op       = xfer.w.op;
    wire logic [15:0]     addr16   = {xfer.w.arg_hi, xfer.w.arg_lo};
    wire logic [FA_W-1:0] fa       = addr16[FA_W-1:0];
    wire logic [EE_W-1:0] ea       = addr16[EE_W-1:0];
    wire logic            word_in  = xfer_valid && xfer.full;
    wire logic            hdr_in   = xfer_valid && !xfer.full && prog_active_reg;
    wire logic            idle     = (eng_reg == ENG_IDLE);
    // New work is refused while a write runs; early access must not corrupt it
    wire logic            cmd_ok   = word_in && prog_active_reg && idle; // R8
    wire logic            enable_hit = word_in && op == OP_ENABLE && xfer.w.arg_hi == ENABLE_ECHO;
    wire logic            erase_go   = cmd_ok && op == OP_ENABLE && xfer.w.arg_hi == ERASE_ARG;
    wire logic            ld_page_go = cmd_ok && op == OP_LOAD_PAGE;
    wire logic            wr_page_go = cmd_ok && op == OP_WRITE_PAGE;
    wire logic            ser_ee_go  = cmd_ok && op == OP_WRITE_EE;

    // ------------------------------------------------------------
    // Parallel command path
    // ------------------------------------------------------------
    wire logic       par_strobe = par_mode_s && par_ld_s && !ld_prev_reg;
    wire logic       par_hi_ok  = pdata_s <= EE_HIGH_MAX;
    wire logic       par_wr_go  = par_mode_s && wr_prev_reg && !par_wr_n_s && !bs1_s
                                  && par_cmd_reg == PAR_CMD_EE_WRITE && idle; // R19
    wire logic       ee_go      = ser_ee_go || par_wr_go;
    wire logic [15:0] par_addr16 = 16'({par_hi_reg, par_lo_reg});

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ld_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b1;
            par_cmd_reg <= 8'h00;
            par_hi_reg  <= 2'h0;
            par_lo_reg  <= 8'h00;
            par_dat_reg <= 8'h00;
        end else begin
            ld_prev_reg <= par_ld_s;
            wr_prev_reg <= par_wr_n_s;
            if (par_strobe && xa_s == PAR_XA_CMD) begin
                par_cmd_reg <= pdata_s; // R18
            end
            if (par_strobe && xa_s == PAR_XA_ADDR && bs1_s && par_hi_ok) begin
                par_hi_reg <= pdata_s[1:0]; // R18
            end
            if (par_strobe && xa_s == PAR_XA_ADDR && !bs1_s) begin
                par_lo_reg <= pdata_s;
            end
            if (par_strobe && xa_s == PAR_XA_DATA && !bs1_s) begin
                par_dat_reg <= pdata_s;
            end
        end
    end

    // ------------------------------------------------------------
    // Write engine
    // ------------------------------------------------------------
    wire logic        tmr_zero    = (timer_reg == 32'h0000_0000);
    wire logic        page_commit = (eng_reg == ENG_PAGE) && tmr_zero;
    wire logic        ee_commit   = (eng_reg == ENG_EE_PROG) && tmr_zero;
    wire logic [31:0] tmr_load    = ee_go ? 32'(EE_WD_CYC) : 32'(FLASH_WD_CYC);
    wire logic        tmr_start   = erase_go || wr_page_go || ee_go;

    always_comb begin
        eng_next = eng_reg;
        unique case (eng_reg)
            ENG_IDLE: begin
                if (erase_go) begin
                    eng_next = ENG_ERASE;
                end else if (wr_page_go) begin
                    eng_next = ENG_PAGE;
                end else if (ee_go) begin
                    eng_next = ENG_EE_CLR;
                end
            end
            ENG_ERASE: begin
                if (tmr_zero) begin
                    eng_next = ENG_IDLE;
                end
            end
            ENG_PAGE: begin
                if (tmr_zero) begin
                    eng_next = ENG_IDLE;
                end
            end
            ENG_EE_CLR: begin
                eng_next = ENG_EE_PROG; // R9
            end
            ENG_EE_PROG: begin
                if (tmr_zero) begin
                    eng_next = ENG_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            eng_reg       <= ENG_IDLE;
            timer_reg     <= 32'h0000_0000;
            sweep_reg     <= '0;
            busy_page_reg <= '0;
            ee_addr_reg   <= '0;
            ee_data_reg   <= 8'h00;
            rdy_reg       <= 1'b1;
        end else begin
            eng_reg   <= eng_next;
            rdy_reg   <= (eng_next == ENG_IDLE); // R20
            timer_reg <= tmr_start ? tmr_load : tmr_zero ? timer_reg : timer_reg - 32'h0000_0001;
            sweep_reg <= erase_go ? '0 : sweep_reg + FA_W'(1);
            if (wr_page_go) begin
                busy_page_reg <= xfer.w.arg_lo[PNUM_W-1:0]; // R7
            end
            if (ee_go) begin
                ee_addr_reg <= par_wr_go ? par_addr16[EE_W-1:0] : ea;
                ee_data_reg <= par_wr_go ? par_dat_reg : xfer.w.data;
            end
        end
    end

    // Flash and EEPROM arrays carry no reset; chip erase brings them back to all ones, and an EEPROM write sets its own byte to all ones first
    always_ff @(posedge mclk_i) begin
        if (eng_reg == ENG_ERASE) begin
            flash_mem[sweep_reg]         <= ERASED_BYTE; // R5
            ee_mem[sweep_reg[EE_W-1:0]] <= ERASED_BYTE;
        end
        if (page_commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                flash_mem[{busy_page_reg, PAGE_W'(i)}] <= flash_mem[{busy_page_reg, PAGE_W'(i)}] & page_buf[i]; // R14
            end
        end
        if (eng_reg == ENG_EE_CLR) begin
            ee_mem[ee_addr_reg] <= ERASED_BYTE; // R9
        end
        if (ee_commit) begin
            ee_mem[ee_addr_reg] <= ee_data_reg;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                page_buf[i] <= ERASED_BYTE;
            end
        end else if (page_commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                page_buf[i] <= ERASED_BYTE;
            end
        end else if (ld_page_go) begin
            page_buf[xfer.w.arg_lo[PAGE_W-1:0]] <= xfer.w.data; // R6
        end
    end

    // ------------------------------------------------------------
    // Mode and read-back
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prog_active_reg <= 1'b0;
        end else if (prog_pin_s) begin
            prog_active_reg <= 1'b0; // R12
        end else if (enable_hit) begin
            prog_active_reg <= 1'b1;
        end
    end

    assign prog_active_o            = prog_active_reg;
    assign program_done_indicator_o = rdy_reg;

    wire logic       page_hit = (eng_reg == ENG_PAGE) && fa[FA_W-1:PAGE_W] == busy_page_reg;
    wire logic       ee_hit   = (eng_reg == ENG_EE_CLR || eng_reg == ENG_EE_PROG) && ea == ee_addr_reg;
    wire logic [7:0] rd_val   = (op == OP_READ_FLASH) ? (page_hit ? ERASED_BYTE : flash_mem[fa]) // R13
                              : (ee_hit ? ERASED_BYTE : ee_mem[ea]); // R16

    mds_word_cdc #(
        .WIDTH      (8)
    ) u_to_link (
        .src_clk_i  (mclk_i),
        .src_rst_i  (rst_i),
        .src_load_i (hdr_in && mds_is_read(op)),
        .src_data_i (rd_val), // R11
        .dst_clk_i  (sck_i),
        .dst_rst_i  (rst_i),
        .dst_valid_o(),
        .dst_data_o (rd_byte_link)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_echo_byte: // R1
    assert property (@(posedge sck_i) disable iff (link_rst)
        (bit_cnt_reg == 6'h0f) |=> (sh_out_reg == $past(sh_in_next[7:0])))
        else $error("second byte not echoed");

    a_read_return: // R11
    assert property (@(posedge sck_i) disable iff (link_rst)
        ret_read |=> (sh_out_reg == $past(rd_byte_link)))
        else $error("read byte not returned");

    a_page_ones: // R13
    assert property (@(posedge mclk_i) disable iff (rst_i)
        (hdr_in && op == OP_READ_FLASH && page_hit) |-> (rd_val == ERASED_BYTE))
        else $error("busy page read not all ones");

    a_ee_ones: // R16
    assert property (@(posedge mclk_i) disable iff (rst_i)
        (hdr_in && op == OP_READ_EE && ee_hit) |-> (rd_val == ERASED_BYTE))
        else $error("busy eeprom read not all ones");

    a_ee_sequence: // R9
    assert property (@(posedge mclk_i) disable iff (rst_i)
        ee_go |=> (eng_reg == ENG_EE_CLR) ##1 (eng_reg == ENG_EE_PROG && ee_mem[ee_addr_reg] == ERASED_BYTE))
        else $error("eeprom erase not before program");

    a_page_load: // R6
    assert property (@(posedge mclk_i) disable iff (rst_i)
        ld_page_go |=> (page_buf[$past(xfer.w.arg_lo[PAGE_W-1:0])] == $past(xfer.w.data)))
        else $error("page buffer byte not loaded");

    a_page_commit: // R7
    assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_page_go |=> (eng_reg == ENG_PAGE && busy_page_reg == $past(xfer.w.arg_lo[PNUM_W-1:0])))
        else $error("page write not started at page");

    a_prog_exit: // R12
    assert property (@(posedge mclk_i) disable iff (rst_i)
        prog_pin_s |=> !prog_active_reg)
        else $error("programming mode kept under reset");

    a_busy_low: // R19
    assert property (@(posedge mclk_i) disable iff (rst_i)
        par_wr_go |=> !rdy_reg [*2])
        else $error("ready not low after write strobe");

    a_ready_high: // R20
    assert property (@(posedge mclk_i) disable iff (rst_i)
        ee_commit |=> rdy_reg && eng_reg == ENG_IDLE)
        else $error("ready not high after write");

    a_high_limit: // R18
    assert property (@(posedge mclk_i) disable iff (rst_i)
        (par_strobe && xa_s == PAR_XA_ADDR && bs1_s && !par_hi_ok) |=> $stable(par_hi_reg))
        else $error("high address beyond limit taken");

    c_enable: cover property (@(posedge mclk_i) disable iff (rst_i) enable_hit && !prog_active_reg);
    c_page:   cover property (@(posedge mclk_i) disable iff (rst_i) page_commit);
    c_par_ee: cover property (@(posedge mclk_i) disable iff (rst_i) par_wr_go ##[1:300] ee_commit);
    c_erase:  cover property (@(posedge mclk_i) disable iff (rst_i) erase_go);

endmodule

`default_nettype wire

// ==== verif/mds_prog_model.sv ====
// Programmer model: drives the serial link of the sequencer.
// Assumes the sequencer samples mosi_o on rising sck_o.
`timescale 1ns/1ps
`default_nettype none

module mds_prog_model (
    // Link
    output logic      sck_o,
    output logic      mosi_o,
    output logic      prog_reset_o,
    input  wire logic miso_i
);
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b1;
        prog_reset_o = 1'b1;
    end
    // Whole instruction always sent; clock idles low between frames
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--) begin
            mosi_o = tx[i];
            #20 rx[i] = miso_i;
            sck_o = 1'b1;
            #40 sck_o = 1'b0;
            #20;
        end
        mosi_o = ~mosi_o;
    endtask
    // Lone clock pulse shifts the framing by one bit
    task automatic pulse();
        sck_o = 1'b1;
        #40 sck_o = 1'b0;
        #40;
    endtask
endmodule

`default_nettype wire

// ==== verif/memory_download_sequencer_tb.sv ====
// Testbench for the sequencer: serial flash/EEPROM flow and parallel write.
// Assumes short write delays so waits stay within a few hundred clocks.
`timescale 1ns/1ps
`default_nettype none

module memory_download_sequencer_tb;
    import mds_pkg::*;
    logic        mclk_i, rst_i, sck, mosi, prst, miso, pm, pl, bs, wr_n, rdy, act;
    logic [1:0]  xa;
    logic [7:0]  pd, d;
    logic [31:0] rx;
    logic [7:0]  m [int];
    int          fails, n_checks, cyc, seed;

    mds_sequencer #(.PAGE_W(2), .PNUM_W(2), .EE_W(4), .FLASH_WD_CYC(200), .EE_WD_CYC(200)) u_mds_sequencer (
        .mclk_i(mclk_i), .rst_i(rst_i), .sck_i(sck), .prog_reset_i(prst), .mosi_i(mosi), .miso_o(miso),
        .par_mode_i(pm), .par_xa_i(xa), .par_load_i(pl), .byte_select_first_i(bs), .par_wr_n_i(wr_n),
        .par_data_i(pd), .program_done_indicator_o(rdy), .prog_active_o(act));
    mds_prog_model u_mds_prog_model (.sck_o(sck), .mosi_o(mosi), .prog_reset_o(prst), .miso_i(miso));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] ex(input int a);
        return m.exists(a) ? m[a] : 8'hff;
    endfunction
    // The reply may miss its own frame end; the third frame's first slot always holds it
    task automatic rd(input logic [7:0] op, input logic [7:0] a, output logic [7:0] q);
        repeat (3) u_mds_prog_model.xfer({op, 8'h00, a, 8'h00}, rx);
        q = rx[31:24];
    endtask
    task automatic wait_rdy();
        for (int i = 0; i < 1000 && rdy !== 1'b1; i++) @(posedge mclk_i);
    endtask
    task automatic enable();
        for (int i = 0; i < 32; i++) begin
            u_mds_prog_model.xfer({OP_ENABLE, ENABLE_ECHO, 16'h0000}, rx);
            if (rx[15:8] === ENABLE_ECHO) break;
            u_mds_prog_model.pulse();
        end
        check(rx[15:8], ENABLE_ECHO);
    endtask
    task automatic pld(input logic [1:0] x, input logic b, input logic [7:0] v);
        @(posedge mclk_i) {xa, bs, pd} <= {x, b, v};
        repeat (3) @(posedge mclk_i);
        pl <= 1'b1;
        repeat (3) @(posedge mclk_i);
        pl <= 1'b0;
        repeat (3) @(posedge mclk_i);
    endtask
    task automatic conclude();
        if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_i, pm, pl, bs, wr_n, xa, pd, seed} = {1'b1, 4'b0001, 10'h0, 32'd45};
        u_mds_prog_model.xfer(32'h0, rx);
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        u_mds_prog_model.prog_reset_o = 1'b0;
        repeat (4) @(posedge mclk_i);
        enable();
        repeat (8) @(posedge mclk_i);
        check({7'h0, act}, 8'h01);
        u_mds_prog_model.xfer({OP_ENABLE, ERASE_ARG, 16'h0000}, rx);
        repeat (400) @(posedge mclk_i);
        u_mds_prog_model.prog_reset_o = 1'b1;
        repeat (4) @(posedge mclk_i);
        u_mds_prog_model.prog_reset_o = 1'b0;
        repeat (4) @(posedge mclk_i);
        enable();
        rd(OP_READ_EE, 8'h07, d);
        check(d, ex(1007));
        rd(OP_READ_FLASH, 8'h04, d);
        check(d, ex(4));
        d = $random(seed);
        m[9] = d;
        u_mds_prog_model.xfer({OP_LOAD_PAGE, 8'h00, 8'h01, d}, rx);
        u_mds_prog_model.xfer({OP_WRITE_PAGE, 8'h00, 8'h02, 8'h00}, rx);
        rd(OP_READ_FLASH, 8'h09, d);
        check(d, ERASED_BYTE);
        rd(OP_READ_FLASH, 8'h08, d);
        check(d, ERASED_BYTE);
        wait_rdy();
        rd(OP_READ_FLASH, 8'h09, d);
        check(d, ex(9));
        d = $random(seed);
        m[1005] = d;
        u_mds_prog_model.xfer({OP_WRITE_EE, 8'h00, 8'h05, d}, rx);
        rd(OP_READ_EE, 8'h05, d);
        check(d, ERASED_BYTE);
        wait_rdy();
        rd(OP_READ_EE, 8'h05, d);
        check(d, ex(1005));
        pm <= 1'b1;
        pld(PAR_XA_CMD, 1'b0, PAR_CMD_EE_WRITE);
        pld(PAR_XA_ADDR, 1'b1, 8'h04);
        pld(PAR_XA_ADDR, 1'b1, EE_HIGH_MAX);
        pld(PAR_XA_ADDR, 1'b0, 8'h02);
        pld(PAR_XA_DATA, 1'b0, 8'h5a);
        wr_n <= 1'b0;
        repeat (6) @(posedge mclk_i);
        check({7'h0, rdy}, 8'h00);
        wr_n <= 1'b1;
        wait_rdy();
        check({7'h0, rdy}, 8'h01);
        rd(OP_READ_EE, 8'h02, d);
        check(d, 8'h5a);
        u_mds_prog_model.prog_reset_o = 1'b1;
        repeat (5) @(posedge mclk_i);
        check({7'h0, act}, 8'h00);
        conclude();
    end
endmodule

`default_nettype wire
